/* verilog/fea_flash_cmd.sv */
// erase and address-mode command interpreter of the serial flash
module fea_flash_cmd
  import fea_pkg::*;
  #(
  parameter int BE_CYCLES = BLOCK_ERASE_CYCLES,
  parameter int CE_CYCLES = CHIP_ERASE_CYCLES
  ) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] dqIn,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe,
  input fea_protect_t protectIn,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic fourByteModeFlag,
  output logic [7:0] highAddressByte,
  output logic [7:0] highAddrBits,
  output logic eraseReq,
  output logic eraseChip,
  output logic [15:0] eraseBlock
  );
  fea_sys_t r_reg, r_next;
  fea_frame_t frame;
  fea_protect_t prot;
  logic csSync;
  logic csRise;
  logic busy;
  logic [7:0] statusByte;
  logic [7:0] statusSync;
  logic [7:0] haSync;
  logic [16:0] protCount;
  logic [15:0] blkIdx;
  logic blkInRange;
  logic blockProt;
  logic anyProt;
  logic frameOp;
  logic frameBlock;
  logic frameChip;
  logic frameHaWrite;
  logic startBlock;
  logic startChip;

  //====================================================================
  // crossings
  // chip select level into the system clock
  fea_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(csN),
    .q(csSync)
  );

  // protection straps, treated as pins
  fea_sync #(
    .W(6),
    .RST_VAL(6'h00)
  ) u_prot_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(protectIn),
    .q(prot)
  );

  // status and high address into the link clock; both are quasi-static
  // and settle within the opcode bits, before any read shifts them out
  fea_sync #(
    .W(16),
    .RST_VAL(16'h0000)
  ) u_rd_sync (
    .clk(sclk),
    .sys_rst(sys_rst),
    .d({statusByte, r_reg.highAddressByte}),
    .q({statusSync, haSync})
  );

  //====================================================================
  // link front end
  fea_link u_link (
    .sclk(sclk),
    .sys_rst(sys_rst),
    .csN(csN),
    .dqIn(dqIn),
    .statusSync(statusSync),
    .haSync(haSync),
    .frame(frame),
    .dqOut(dqOut),
    .dqOe(dqOe)
  );

  //====================================================================
  // protection decode
  // level n protects 2^(n-1) blocks from the top, or bottom when selected;
  // the top level covers the whole span, complement inverts the area
  always_comb begin
    if (prot.blockProtect == 4'h0) begin
      protCount = 17'h0;
    end else if (prot.blockProtect == BP_ALL) begin
      protCount = BLOCK_SPAN;
    end else begin
      protCount = 17'h1 << (prot.blockProtect - 4'h1);
    end
  end

  // any address inside the block picks the block
  assign blkIdx = frame.payload[31:16];
  assign blkInRange = prot.topBottomSelect ? ({1'b0, blkIdx} < protCount)
                                           : ({1'b0, blkIdx} >= BLOCK_SPAN - protCount);
  assign blockProt = prot.protectComplement ? !blkInRange : blkInRange;
  assign anyProt = prot.protectComplement ? (protCount != BLOCK_SPAN) : (protCount != 17'h0);

  //====================================================================
  // frame qualification
  // the frame registers are stable once chip select is high, since the
  // host stops sclk; the synchronised edge marks when to read them
  assign csRise = csSync && !r_reg.csPrev;
  assign busy = r_reg.mode != FEA_IDLE;
  assign frameOp = frame.bitCount == CNT_OPCODE;
  assign frameBlock = (frame.opcode == OP_BLOCK_ERASE_WIDE) && (frame.bitCount == CNT_WIDE_ADDR);
  assign frameChip = ((frame.opcode == OP_CHIP_ERASE_A) || (frame.opcode == OP_CHIP_ERASE_B)) && frameOp;
  assign frameHaWrite = (frame.opcode == OP_HA_WRITE) && (frame.bitCount == CNT_HA_WRITE);
  assign startBlock = csRise && !busy && frameBlock && r_reg.writeEnableLatch && !blockProt;
  assign startChip = csRise && !busy && frameChip && r_reg.writeEnableLatch && !anyProt;

  //====================================================================
  // command execution and erase timer
  always_comb begin
    r_next = r_reg;
    r_next.csPrev = csSync;
    r_next.eraseReq = 1'b0;
    // self-timed cycle counts down to the end of the busy window
    if (busy) begin
      if (r_reg.timer <= 32'h1) begin
        r_next.timer = 32'h0;
        r_next.mode = FEA_IDLE;
      end else begin
        r_next.timer = r_reg.timer - 32'h1;
      end
    end
    // commands other than reads and the quad mode enter/exit are not decoded during a cycle
    if (csRise && !busy) begin
      if ((frame.opcode == OP_WRITE_ENABLE) && frameOp) begin
        r_next.writeEnableLatch = 1'b1;
      end
      if ((frame.opcode == OP_ENTER_WIDE) && frameOp) begin
        r_next.fourByteModeFlag = 1'b1;
      end
      if ((frame.opcode == OP_EXIT_WIDE) && frameOp) begin
        r_next.fourByteModeFlag = 1'b0;
      end
      if (frameHaWrite && r_reg.writeEnableLatch) begin
        r_next.highAddressByte = frame.payload[7:0];
        r_next.writeEnableLatch = 1'b0;
      end
      // in 4-byte mode a full wide address carries A31-A24
      if (frameBlock && r_reg.fourByteModeFlag) begin
        r_next.highAddressByte = frame.payload[31:24];
      end
    end
    if (startBlock) begin
      r_next.mode = FEA_BLOCK;
      r_next.timer = 32'(BE_CYCLES);
      r_next.writeEnableLatch = 1'b0;
      r_next.eraseReq = 1'b1;
      r_next.eraseChip = 1'b0;
      r_next.eraseBlock = blkIdx;
    end
    if (startChip) begin
      r_next.mode = FEA_CHIP;
      r_next.timer = 32'(CE_CYCLES);
      r_next.writeEnableLatch = 1'b0;
      r_next.eraseReq = 1'b1;
      r_next.eraseChip = 1'b1;
      r_next.eraseBlock = 16'h0;
    end
  end

  // reset leaves 3-byte mode and a cleared high address byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.csPrev <= 1'b1;
      r_reg.highAddressByte <= HA_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  //====================================================================
  // outputs
  assign writeInProgress = busy;
  assign writeEnableLatch = r_reg.writeEnableLatch;
  assign fourByteModeFlag = r_reg.fourByteModeFlag;
  assign highAddressByte = r_reg.highAddressByte;
  // 4-byte mode zeroes the high address bits; 3-byte mode supplies the register
  assign highAddrBits = r_reg.fourByteModeFlag ? 8'h00 : r_reg.highAddressByte;
  assign eraseReq = r_reg.eraseReq;
  assign eraseChip = r_reg.eraseChip;
  assign eraseBlock = r_reg.eraseBlock;
  // status layout seen by the status read
  assign statusByte = {prot.protectComplement, prot.topBottomSelect, prot.blockProtect,
                       r_reg.writeEnableLatch, busy};

  //====================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // erase never starts with the latch clear
  property p_erase_needs_wel;
    (startBlock || startChip) |-> r_reg.writeEnableLatch;
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel)
    else $error("erase started without write enable");

  // block erase needs exactly opcode plus four bytes
  property p_block_len;
    startBlock |-> (frame.bitCount == 7'h28) && (frame.opcode == 8'hdc);
  endproperty
  a_block_len: assert property (p_block_len)
    else $error("block erase started on a wrong frame length");

  // chip erase needs exactly eight bits
  property p_chip_len;
    startChip |-> frame.bitCount == 7'h08;
  endproperty
  a_chip_len: assert property (p_chip_len)
    else $error("chip erase started on a wrong frame length");

  // busy is raised at once and held through the early cycles
  property p_busy_start;
    startBlock |=> writeInProgress [*8] ##0 (eraseBlock == $past(blkIdx, 8));
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not held after block erase start");

  // latch gone right after the cycle starts
  property p_wel_cleared;
    (startBlock || startChip) |=> !writeEnableLatch && eraseReq;
  endproperty
  a_wel_cleared: assert property (p_wel_cleared)
    else $error("write enable latch survived erase start");

  // busy falls only when the timer runs out
  property p_busy_end;
    $fell(writeInProgress) |-> $past(r_reg.timer) == 32'h1;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy fell before the erase time");

  // no erase on a protected block
  property p_protect_block;
    (csRise && frameBlock && blockProt) |=> !eraseReq;
  endproperty
  a_protect_block: assert property (p_protect_block)
    else $error("protected block was erased");

  // chip erase refused with any protection
  property p_protect_chip;
    (csRise && frameChip && anyProt) |=> !eraseReq && (eraseChip == $past(eraseChip));
  endproperty
  a_protect_chip: assert property (p_protect_chip)
    else $error("chip erase ran with protection set");

  // enter and exit of wide mode
  property p_wide_mode;
    (csRise && !busy && frameOp && frame.opcode == 8'hb7) |=> fourByteModeFlag ##1 (highAddrBits == 8'h00);
  endproperty
  a_wide_mode: assert property (p_wide_mode)
    else $error("wide mode not entered");

  property p_narrow_mode;
    (csRise && !busy && frameOp && frame.opcode == 8'he9) |=> !fourByteModeFlag;
  endproperty
  a_narrow_mode: assert property (p_narrow_mode)
    else $error("wide mode not left");

  // high address changes only by a write with latch, or a wide address
  property p_ha_write;
    $changed(highAddressByte) |-> $past(frameHaWrite && r_reg.writeEnableLatch)
                                  || $past(frameBlock && r_reg.fourByteModeFlag);
  endproperty
  a_ha_write: assert property (p_ha_write)
    else $error("high address byte changed without cause");

  // in 4-byte mode a wide address feeds A31-A24 into the register
  property p_ha_wide;
    (csRise && !busy && frameBlock && r_reg.fourByteModeFlag)
      |=> highAddressByte == $past(frame.payload[31:24]);
  endproperty
  a_ha_wide: assert property (p_ha_wide)
    else $error("wide address did not update high address byte");

  // 3-byte mode supplies the register as upper bits
  property p_ha_use;
    !fourByteModeFlag |-> highAddrBits == highAddressByte;
  endproperty
  a_ha_use: assert property (p_ha_use)
    else $error("high address bits not supplied in 3-byte mode");

  // write enable sets the latch when no cycle runs
  property p_wel_set;
    (csRise && !busy && frameOp && frame.opcode == OP_WRITE_ENABLE) |=> writeEnableLatch;
  endproperty
  a_wel_set: assert property (p_wel_set)
    else $error("write enable did not set the latch");

  // chip erase holds busy through its early cycles
  property p_chip_busy;
    startChip |=> writeInProgress [*8] ##0 eraseChip;
  endproperty
  a_chip_busy: assert property (p_chip_busy)
    else $error("busy not held after chip erase start");

  // whole array erase is flagged with no block index
  property p_chip_erase;
    startChip |=> eraseReq && eraseChip && (eraseBlock == 16'h0);
  endproperty
  a_chip_erase: assert property (p_chip_erase)
    else $error("chip erase not handed over");

  // block erase hands over the addressed block
  property p_block_idx;
    startBlock |=> eraseReq && !eraseChip && (eraseBlock == $past(blkIdx));
  endproperty
  a_block_idx: assert property (p_block_idx)
    else $error("block erase handed over a wrong block");

  // commands during a cycle neither start erases nor touch the latch
  property p_busy_ignore;
    (csRise && busy) |=> !eraseReq && $stable(writeEnableLatch);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("command acted on during an erase cycle");

  // main scenarios
  c_block_erase: cover property (startBlock ##1 writeInProgress);
  c_chip_erase: cover property (startChip ##1 eraseChip);
  c_wide_enter: cover property ($rose(fourByteModeFlag));
  c_ha_written: cover property (csRise && frameHaWrite && r_reg.writeEnableLatch);
endmodule

/* verilog/fea_pkg.sv */
// package: opcodes, timing, protection span and carrier types of the erase/address-mode block
//====================================================================
package fea_pkg;
  //====================================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_BLOCK_ERASE_WIDE = 8'hdc;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
  localparam logic [7:0] OP_EXIT_WIDE = 8'he9;
  localparam logic [7:0] OP_HA_READ = 8'hc8;
  localparam logic [7:0] OP_HA_WRITE = 8'hc5;
  localparam logic [7:0] OP_QPI_ENTER = 8'h38;
  localparam logic [7:0] OP_QPI_EXIT = 8'hff;
  //====================================================================
  // frame lengths in bits
  localparam logic [6:0] CNT_OPCODE = 7'h08;
  localparam logic [6:0] CNT_HA_WRITE = 7'h10;
  localparam logic [6:0] CNT_WIDE_ADDR = 7'h28;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [7:0] HA_RESET = 8'h00;
  //====================================================================
  // timing
  localparam int CLK_MHZ = 40;
  localparam int BLOCK_ERASE_TIME_US = 500;
  localparam int CHIP_ERASE_TIME_US = 20000;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
  //====================================================================
  // protection: 16-bit block index, full span
  localparam logic [16:0] BLOCK_SPAN = 17'h10000;
  localparam logic [3:0] BP_ALL = 4'hf;
  //====================================================================
  // carriers
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] payload;
    logic [6:0] bitCount;
  } fea_frame_t;
  typedef struct packed {
    logic protectComplement;
    logic topBottomSelect;
    logic [3:0] blockProtect;
  } fea_protect_t;
  typedef enum logic [1:0] {
    FEA_IDLE = 2'b00,
    FEA_BLOCK = 2'b01,
    FEA_CHIP = 2'b10
  } fea_erase_t;
  typedef struct packed {
    logic csPrev;
    logic writeEnableLatch;
    logic fourByteModeFlag;
    logic [7:0] highAddressByte;
    logic [31:0] timer;
    fea_erase_t mode;
    logic eraseReq;
    logic eraseChip;
    logic [15:0] eraseBlock;
  } fea_sys_t;
endpackage

/* verilog/fea_sync.sv */
// two-flop level synchroniser
module fea_sync
  import fea_pkg::*;
  #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
  ) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
  );
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fea_sync_t;
  fea_sync_t r_reg, r_next;
  //====================================================================
  // first stage feeds only the second
  always_comb begin
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= {RST_VAL, RST_VAL};
    end else begin
      r_reg <= r_next;
    end
  end
  assign q = r_reg.s2;
endmodule

/* verilog/fea_link.sv */
// serial link front end on the host clock: shifts frames in, shifts read bytes out
module fea_link
  import fea_pkg::*;
  (
  input wire logic sclk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire logic [3:0] dqIn,
  input wire logic [7:0] statusSync,
  input wire logic [7:0] haSync,
  output fea_frame_t frame,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe
  );
  typedef struct packed {
    fea_frame_t f;
    logic qpi;
    logic enterPend;
    logic exitPend;
  } fea_link_t;
  fea_link_t r_reg, r_next;
  logic armed_reg;
  logic armSet;
  logic qpiNow;
  logic [6:0] cnt, step;
  logic [7:0] rdByte;
  logic rdOp;
  //====================================================================
  // armed is set while deselected, so the sclk clock may stop freely;
  // the frame stays held for the system side after chip select rises
  assign armSet = csN | sys_rst;
  always_ff @(posedge sclk or posedge armSet) begin
    if (armSet) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end
  //====================================================================
  // bit counter, opcode and payload shifters
  always_comb begin
    r_next = r_reg;
    qpiNow = r_reg.qpi;
    if (armed_reg && r_reg.enterPend) begin
      qpiNow = 1'b1;
    end
    if (armed_reg && r_reg.exitPend) begin
      qpiNow = 1'b0;
    end
    r_next.qpi = qpiNow;
    step = qpiNow ? 7'h04 : 7'h01;
    cnt = armed_reg ? 7'h00 : r_reg.f.bitCount;
    if (armed_reg) begin
      r_next.f.opcode = 8'h00;
      r_next.f.payload = 32'h0;
    end
    if (cnt < CNT_OPCODE) begin
      r_next.f.opcode = qpiNow ? {r_next.f.opcode[3:0], dqIn} : {r_next.f.opcode[6:0], dqIn[0]};
    end else begin
      r_next.f.payload = qpiNow ? {r_next.f.payload[27:0], dqIn} : {r_next.f.payload[30:0], dqIn[0]};
    end
    r_next.f.bitCount = (cnt > CNT_MAX - step) ? CNT_MAX : cnt + step;
    r_next.enterPend = (r_next.f.bitCount == CNT_OPCODE) && !qpiNow && (r_next.f.opcode == OP_QPI_ENTER);
    r_next.exitPend = (r_next.f.bitCount == CNT_OPCODE) && qpiNow && (r_next.f.opcode == OP_QPI_EXIT);
  end
  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign frame = r_reg.f;
  //====================================================================
  // read data changes on falling edges, msb first
  assign rdOp = (r_reg.f.opcode == OP_HA_READ) || (r_reg.f.opcode == OP_STATUS_READ);
  assign rdByte = (r_reg.f.opcode == OP_HA_READ) ? haSync : statusSync;
  always_ff @(negedge sclk or posedge armSet) begin
    if (armSet) begin
      dqOut <= 4'h0;
      dqOe <= 4'h0;
    end else if (!armed_reg && rdOp && r_reg.f.bitCount >= CNT_OPCODE) begin
      if (r_reg.qpi) begin
        dqOut <= r_reg.f.bitCount[2] ? rdByte[3:0] : rdByte[7:4];
        dqOe <= 4'hf;
      end else begin
        dqOut <= {2'b00, rdByte[3'h7 - r_reg.f.bitCount[2:0]], 1'b0};
        dqOe <= 4'h2;
      end
    end else begin
      dqOut <= 4'h0;
      dqOe <= 4'h0;
    end
  end
endmodule

/* tb/fea_host_model.sv */
// behavioural serial host: frames commands on its own link clock, reads answer bytes
module fea_host_model
  import fea_pkg::*;
  (
  output logic sclk,
  output logic csN,
  output logic [3:0] dqIn,
  input wire logic [3:0] dqOut,
  input wire logic [3:0] dqOe
  );
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] oeLast;
  //====================================================================
  // idle: clock parked low, select high
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dqIn = 4'h5;
    oeLast = 4'h0;
  end
  //====================================================================
  // one frame: opcode, payBits of pay (msb first), then rdBits of answer
  task automatic xfer(input logic [7:0] op, input logic [31:0] pay, input int payBits, input bit q,
                      input int rdBits, output logic [7:0] rd);
    logic [47:0] sh;
    int w;
    sh = {op, pay, 8'h00};
    w = q ? 4 : 1;
    rd = 8'h00;
    csN = 1'b0;
    #10;
    // 15 ns link clock, runs only while selected
    for (int i = 0; i < 8 + payBits; i += w) begin
      dqIn = q ? sh[47:44] : {~dqIn[3:1], sh[47]};
      sh = sh << w;
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    for (int i = 0; i < rdBits; i += w) begin
      dqIn = ~dqIn; // released lines keep moving, no stale value
      #7.5 sclk = 1'b1;
      rd = q ? {rd[3:0], dqOut} : {rd[6:0], dqOut[1]};
      oeLast = dqOe;
      #7.5 sclk = 1'b0;
    end
    // select rises right after last bit; quiet gap covers the clk-side decode
    #7.5 csN = 1'b1;
    dqIn = ~dqIn;
    #150;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench of the erase and address-mode command interpreter
module testbench
  import fea_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BE_N = 80;
  localparam int CE_N = 120;
  localparam int LIMIT = 20000;
  logic clk, sys_rst, sclk, csN;
  logic [3:0] dqIn, dqOut, dqOe;
  fea_protect_t protectIn;
  logic writeInProgress, writeEnableLatch, fourByteModeFlag, eraseReq, eraseChip;
  logic [7:0] highAddressByte, highAddrBits, rd, ha;
  logic [15:0] eraseBlock;
  logic [31:0] addr;
  int error_cnt, cmp_count, cycles, reqCount, busyRun, lastRun, seed;
  //====================================================================
  // clock and instances
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fea_flash_cmd #(.BE_CYCLES(BE_N), .CE_CYCLES(CE_N)) dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .protectIn(protectIn),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
    .fourByteModeFlag(fourByteModeFlag), .highAddressByte(highAddressByte), .highAddrBits(highAddrBits),
    .eraseReq(eraseReq), .eraseChip(eraseChip), .eraseBlock(eraseBlock));
  fea_host_model host (.sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
  //====================================================================
  // watchdog, erase start pulses and busy length
  always @(posedge clk) begin
    cycles++;
    if (eraseReq === 1'b1) reqCount++;
    if (writeInProgress === 1'b1) busyRun++;
    else if (busyRun != 0) begin
      lastRun = busyRun;
      busyRun = 0;
    end
    if (cycles == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end
  //====================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] statusOf(fea_protect_t p, logic write_enable_latch, logic write_in_progress);
    return {p, write_enable_latch, write_in_progress};
  endfunction
  // a frame, then room for the clk side to act on it
  task automatic frame(input logic [7:0] op, input logic [31:0] pay, input int bits, input bit q, input int rdb);
    host.xfer(op, pay, bits, q, rdb, rd);
    repeat (6) @(posedge clk);
  endtask
  task automatic erase(input logic [7:0] op, input logic [31:0] a, input int bits, input bit q, input bit go);
    int r0;
    r0 = reqCount;
    frame(op, a, bits, q, 0);
    check(reqCount - r0, go);
    if (go) begin
      check(writeInProgress, 1'b1);
      check(writeEnableLatch, 1'b0);
      check(eraseChip, op != OP_BLOCK_ERASE_WIDE);
      check(eraseBlock, bits == 0 ? 16'h0 : a[31:16]);
      frame(OP_STATUS_READ, 32'h0, 0, q, 8);
      check(rd, statusOf(protectIn, 1'b0, 1'b1));
      // write enable while busy must not set the latch again
      frame(OP_WRITE_ENABLE, 32'h0, 0, q, 0);
      check(writeEnableLatch, 1'b0);
      for (int n = 0; n < 3000 && writeInProgress !== 1'b0; n++) @(posedge clk);
      @(posedge clk);
      check(lastRun, bits == 0 ? CE_N : BE_N);
    end
  endtask
  task automatic wen(input bit q);
    frame(OP_WRITE_ENABLE, 32'h0, 0, q, 0);
    check(writeEnableLatch, 1'b1);
  endtask
  task automatic doReset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({highAddressByte, fourByteModeFlag, writeEnableLatch, writeInProgress}, 32'h0);
  endtask
  //====================================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    protectIn = '0;
    seed = 32'hb351aca0;
    doReset();
    addr = $random(seed);
    erase(OP_BLOCK_ERASE_WIDE, addr, 32, 0, 0);
    wen(0);
    erase(OP_BLOCK_ERASE_WIDE, addr, 31, 0, 0);
    erase(OP_BLOCK_ERASE_WIDE, addr, 33, 0, 0);
    erase(OP_BLOCK_ERASE_WIDE, addr, 32, 0, 1);
    // everything protected: both erase kinds refused, latch kept
    @(posedge clk);
    protectIn <= '{1'b0, 1'b0, BP_ALL};
    wen(0);
    erase(OP_BLOCK_ERASE_WIDE, $random(seed), 32, 0, 0);
    erase(OP_CHIP_ERASE_A, 32'h0, 0, 0, 0);
    @(posedge clk);
    protectIn <= '0;
    erase(OP_CHIP_ERASE_A, 32'h8000_0000, 1, 0, 0);
    erase(OP_CHIP_ERASE_A, 32'h0, 0, 0, 1);
    wen(0);
    erase(OP_CHIP_ERASE_B, 32'h0, 0, 0, 1);
    // wide mode, address top byte lands in the register
    frame(OP_ENTER_WIDE, 32'h0, 0, 0, 0);
    check({fourByteModeFlag, highAddrBits}, 32'h100);
    addr = $random(seed);
    wen(0);
    erase(OP_BLOCK_ERASE_WIDE, addr, 32, 0, 1);
    check(highAddressByte, addr[31:24]);
    frame(OP_EXIT_WIDE, 32'h0, 0, 0, 0);
    check(fourByteModeFlag, 1'b0);
    check(highAddrBits, addr[31:24]);
    frame(OP_HA_READ, 32'h0, 0, 0, 8);
    check(rd, addr[31:24]);
    check(host.oeLast, 4'h2);
    // register write refused without latch, then random write/read pairs
    frame(OP_HA_WRITE, 32'h5a00_0000, 8, 0, 0);
    check(highAddressByte, addr[31:24]);
    repeat (4) begin
      ha = $random(seed);
      wen(0);
      frame(OP_HA_WRITE, {ha, 24'h0}, 8, 0, 0);
      check(highAddressByte, ha);
      frame(OP_HA_READ, 32'h0, 0, 0, 8);
      check(rd, ha);
    end
    // quad peripheral mode: same commands on four lines
    frame(OP_QPI_ENTER, 32'h0, 0, 0, 0);
    ha = $random(seed);
    wen(1);
    frame(OP_HA_WRITE, {ha, 24'h0}, 8, 1, 0);
    frame(OP_HA_READ, 32'h0, 0, 1, 8);
    check(rd, ha);
    check(host.oeLast, 4'hf);
    wen(1);
    erase(OP_BLOCK_ERASE_WIDE, $random(seed), 32, 1, 1);
    frame(OP_ENTER_WIDE, 32'h0, 0, 1, 0);
    check(fourByteModeFlag, 1'b1);
    frame(OP_EXIT_WIDE, 32'h0, 0, 1, 0);
    check(fourByteModeFlag, 1'b0);
    frame(OP_QPI_EXIT, 32'h0, 0, 1, 0);
    frame(OP_HA_READ, 32'h0, 0, 0, 8);
    check(rd, ha);
    // second reset in mid-run clears mode and register
    frame(OP_ENTER_WIDE, 32'h0, 0, 0, 0);
    doReset();
    give_verdict();
  end
endmodule
